//--- inc/phyp_map.vh
// Constants for the gigabit MAC-side port of the transceiver
`ifndef PHYP_MAP_VH
`define PHYP_MAP_VH
`define PHYP_SEL_GMII      3'h0
`define PHYP_SEL_RGMII_A   3'h4
`define PHYP_SEL_RGMII_B   3'h6
`define PHYP_MODE_OFF      2'h0
`define PHYP_MODE_GMII     2'h1
`define PHYP_MODE_RGMII    2'h2
`define PHYP_RX_HALF       3'h2
`define PHYP_RX_HALF_W     3
`define PHYP_NIB_LO        3:0
`define PHYP_NIB_HI        7:4
`endif

//--- hdl/phyp_mac_port.v
// MAC-side GMII / RGMII data port of the transceiver
`timescale 1ns/1ps
`default_nettype none
`include "phyp_map.vh"
module phyp_mac_port
(
   input  wire       clk,            // System clock
   input  wire       rst,            // Async reset, active high
   input  wire [2:0] host_port_variant_select, // Strap pins
   input  wire       speed_1000,     // Negotiated gigabit speed, internal
   input  wire       half_duplex,    // Half-duplex operation, internal
   input  wire       crs_on_tx_en,   // Carrier sense on transmit enable
   input  wire       rx_active,      // Receive medium busy, internal
   input  wire       tx_active,      // Transmit medium busy, internal
   input  wire       line_rx_valid,  // Decoded receive byte valid
   input  wire       line_rx_err,    // Receive byte is in errored frame
   input  wire [7:0] line_rx_data,   // Decoded receive byte
   input  wire       gtx_clk,        // MAC transmit clock pin
   input  wire       tx_en,          // Transmit enable / control pin
   input  wire       tx_er,          // Transmit error pin
   input  wire [7:0] txd,            // Transmit data pins
   output reg        line_rx_take,   // Receive byte consumed pulse
   output reg        line_tx_valid,  // Transmit byte strobe
   output reg        line_tx_en,     // Transmit enable of the byte
   output reg        line_tx_err,    // Transmit error of the byte
   output reg  [7:0] line_tx_data,   // Transmit byte to line side
   output reg  [1:0] port_mode,      // Latched port mode
   output reg        rx_clk,         // Receive clock pin
   output reg        rx_dv,          // Receive valid / control pin
   output reg        rx_er,          // Receive error pin
   output reg  [7:0] rxd,            // Receive data pins
   output reg        crs,            // Carrier sense pin
   output reg        col             // Collision pin
);

   reg [2:0] sel_s1_ff;
   reg [2:0] sel_s2_ff;
   reg       strap_done_ff;
   reg [1:0] mode_ff;
   reg [1:0] nxt_mode;
   reg       gclk_s1_ff;
   reg       gclk_s2_ff;
   reg       gclk_d_ff;
   reg [9:0] tx_s1_ff;
   reg [9:0] tx_s2_ff;
   reg [3:0] lo_nib_ff;
   reg       lo_ctl_ff;
   reg [`PHYP_RX_HALF_W-1:0] div_ff;
   reg       hold_dv_ff;
   reg       hold_er_ff;
   reg [7:0] hold_d_ff;
   wire      gmii_on;
   wire      rgmii_on;
   wire      g_rise;
   wire      g_fall;
   wire      half_end;

   always @*
   begin
      case (sel_s2_ff)
         `PHYP_SEL_GMII:    nxt_mode = `PHYP_MODE_GMII;
         `PHYP_SEL_RGMII_A: nxt_mode = `PHYP_MODE_RGMII;
         `PHYP_SEL_RGMII_B: nxt_mode = `PHYP_MODE_RGMII;
         default:           nxt_mode = `PHYP_MODE_OFF;
      endcase
   end

   // Strap sync left unreset, so the pin levels reach flop 2 while reset is held
   always @(posedge clk)
   begin
      sel_s1_ff <= host_port_variant_select;
      sel_s2_ff <= sel_s1_ff;
   end

   // Strap taken once, on the first edge after release of reset
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         strap_done_ff <= 1'b0;
         mode_ff       <= `PHYP_MODE_OFF;
         port_mode     <= `PHYP_MODE_OFF;
      end
      else
      begin
         if (!strap_done_ff)
         begin
            strap_done_ff <= 1'b1;
            mode_ff       <= nxt_mode;
            port_mode     <= nxt_mode;
         end
      end
   end

   // Either path only runs at gigabit speed; slower rates are not handled here
   assign gmii_on  = (mode_ff == `PHYP_MODE_GMII) && speed_1000;
   assign rgmii_on = (mode_ff == `PHYP_MODE_RGMII) && speed_1000;

   // Pins and MAC clock pass two flops; data keeps the same latency as its clock
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gclk_s1_ff <= 1'b0;
         gclk_s2_ff <= 1'b0;
         gclk_d_ff  <= 1'b0;
         tx_s1_ff   <= 10'h000;
         tx_s2_ff   <= 10'h000;
      end
      else
      begin
         gclk_s1_ff <= gtx_clk;
         gclk_s2_ff <= gclk_s1_ff;
         gclk_d_ff  <= gclk_s2_ff;
         tx_s1_ff   <= {tx_er, tx_en, txd};
         tx_s2_ff   <= tx_s1_ff;
      end
   end

   assign g_rise = gclk_s2_ff && !gclk_d_ff;
   assign g_fall = !gclk_s2_ff && gclk_d_ff;

   // A clock held low by the MAC yields no edges, so no bytes
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lo_nib_ff     <= 4'h0;
         lo_ctl_ff     <= 1'b0;
         line_tx_valid <= 1'b0;
         line_tx_en    <= 1'b0;
         line_tx_err   <= 1'b0;
         line_tx_data  <= 8'h00;
      end
      else
      begin
         line_tx_valid <= 1'b0;
         if (gmii_on && g_rise)
         begin
            line_tx_valid <= 1'b1;
            line_tx_data  <= tx_s2_ff[7:0];
            line_tx_en    <= tx_s2_ff[8];
            line_tx_err   <= tx_s2_ff[9];
         end
         else if (rgmii_on && g_rise)
         begin
            lo_nib_ff <= tx_s2_ff[3:0];
            lo_ctl_ff <= tx_s2_ff[8];
         end
         else if (rgmii_on && g_fall)
         begin
            line_tx_valid <= 1'b1;
            line_tx_data  <= {tx_s2_ff[3:0], lo_nib_ff};
            line_tx_en    <= lo_ctl_ff;
            line_tx_err   <= lo_ctl_ff ^ tx_s2_ff[8];
         end
      end
   end

   // Receive clock is a divided system clock; runs only while a path is active
   assign half_end = (div_ff == `PHYP_RX_HALF - 3'h1);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_ff       <= {`PHYP_RX_HALF_W{1'b0}};
         rx_clk       <= 1'b0;
         hold_dv_ff   <= 1'b0;
         hold_er_ff   <= 1'b0;
         hold_d_ff    <= 8'h00;
         line_rx_take <= 1'b0;
         rx_dv        <= 1'b0;
         rx_er        <= 1'b0;
         rxd          <= 8'h00;
      end
      else if (!(gmii_on || rgmii_on))
      begin
         div_ff       <= {`PHYP_RX_HALF_W{1'b0}};
         rx_clk       <= 1'b0;
         hold_dv_ff   <= 1'b0;
         hold_er_ff   <= 1'b0;
         line_rx_take <= 1'b0;
         rx_dv        <= 1'b0;
         rx_er        <= 1'b0;
         rxd          <= 8'h00;
      end
      else
      begin
         line_rx_take <= 1'b0;
         if (half_end)
            div_ff <= {`PHYP_RX_HALF_W{1'b0}};
         else
            div_ff <= div_ff + 3'h1;
         if (half_end && !rx_clk)
         begin
            // Rising edge: one byte per receive clock period
            rx_clk       <= 1'b1;
            hold_dv_ff   <= line_rx_valid;
            hold_er_ff   <= line_rx_err;
            hold_d_ff    <= line_rx_data;
            line_rx_take <= 1'b1;
            if (rgmii_on)
            begin
               rxd   <= {4'h0, line_rx_data[`PHYP_NIB_LO]};
               rx_dv <= line_rx_valid;
               rx_er <= 1'b0;
            end
         end
         else if (half_end && rx_clk)
         begin
            rx_clk <= 1'b0;
            if (gmii_on)
            begin
               // Launched on the fall so the MAC sees stable data at the rise
               rxd   <= hold_d_ff;
               rx_dv <= hold_dv_ff;
               rx_er <= hold_dv_ff && hold_er_ff;
            end
            else
            begin
               rxd   <= {4'h0, hold_d_ff[`PHYP_NIB_HI]};
               rx_dv <= hold_dv_ff ^ hold_er_ff;
               rx_er <= 1'b0;
            end
         end
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         crs <= 1'b0;
      end
      else
      begin
         // Transmit activity only counts when the option is enabled
         crs <= rx_active ||
                (half_duplex && crs_on_tx_en && tx_active);
      end
   end

   // Full duplex never reports a collision
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         col <= 1'b0;
      end
      else
      begin
         col <= half_duplex && rx_active && tx_active;
      end
   end

endmodule
`default_nettype wire

//--- testbench/phyp_props.sv
// Checker bound to the MAC-side port
`timescale 1ns/1ps
`default_nettype none
`include "phyp_map.vh"
module phyp_props
(
   input wire logic       clk,           // In
   input wire logic       rst,           // In
   input wire logic       half_duplex,   // In
   input wire logic       crs_on_tx_en,  // In
   input wire logic       rx_active,     // In
   input wire logic       tx_active,     // In
   input wire logic       line_rx_valid, // In
   input wire logic       line_rx_err,   // In
   input wire logic [7:0] line_rx_data,  // In
   input wire logic       line_rx_take,  // Out
   input wire logic       line_tx_valid, // Out
   input wire logic [1:0] port_mode,     // Out
   input wire logic       rx_clk,        // Out
   input wire logic       rx_dv,         // Out
   input wire logic       rx_er,         // Out
   input wire logic [7:0] rxd,           // Out
   input wire logic       crs,           // Out
   input wire logic       col            // Out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_crs; 1 |=> crs == $past(rx_active | (half_duplex & crs_on_tx_en & tx_active)); endproperty
   a_crs: assert property (p_crs) else $error("carrier sense mismatch");
   property p_col; 1 |=> col == $past(half_duplex & rx_active & tx_active); endproperty
   a_col: assert property (p_col) else $error("collision mismatch");
   property p_mode; port_mode != 2'h3 && ($past(port_mode) == 2'h0 || $stable(port_mode)); endproperty
   a_mode: assert property (p_mode) else $error("port mode changed");
   property p_txv; line_tx_valid |=> !line_tx_valid; endproperty
   a_txv: assert property (p_txv) else $error("transmit strobe too long");
   property p_hi; $rose(rx_clk) |=> rx_clk ##1 !rx_clk; endproperty
   a_hi: assert property (p_hi) else $error("receive clock phase wrong");
   property p_take; line_rx_take == $rose(rx_clk); endproperty
   a_take: assert property (p_take) else $error("byte taken off clock rise");
   property p_gm; $fell(rx_clk) && port_mode == `PHYP_MODE_GMII |-> rx_dv == $past(line_rx_valid, 3)
      && rx_er == $past(line_rx_valid & line_rx_err, 3) && (!rx_dv || rxd == $past(line_rx_data, 3)); endproperty
   a_gm: assert property (p_gm) else $error("wide receive byte wrong");
   property p_rg; $rose(rx_clk) && port_mode == `PHYP_MODE_RGMII |-> rx_dv == $past(line_rx_valid)
      && rxd == ($past(line_rx_data) & 8'h0F) && !rx_er; endproperty
   a_rg: assert property (p_rg) else $error("low nibble wrong");
   c_gm: cover property ($fell(rx_clk) && rx_dv && port_mode == `PHYP_MODE_GMII);
   c_rg: cover property ($rose(rx_clk) && rx_dv && port_mode == `PHYP_MODE_RGMII);
   c_col: cover property (col);
endmodule
bind phyp_mac_port phyp_props chk_u (.*);
`default_nettype wire

//--- testbench/phyp_mac_model.sv
// MAC transmit side: link clock and data pins
`timescale 1ns/1ps
`default_nettype none
module phyp_mac_model
(
   input  wire logic       rgmii,   // Reduced framing
   output var  logic       gtx_clk, // Link clock
   output var  logic       tx_en,   // Enable or control
   output var  logic       tx_er,   // Error
   output var  logic [7:0] txd      // Data
);
   initial {gtx_clk, tx_en, tx_er, txd} = 11'h000;
   // Clock stands between bytes; spare pins toggle so stale levels never match
   task send(input logic [7:0] b, input logic en, input logic er);
      txd = rgmii ? {~b[7:4], b[3:0]} : b;
      tx_en = en;
      tx_er = rgmii ? ~er : er;
      gtx_clk = 1'b1;
      #100;
      txd = rgmii ? {b[7:4], b[7:4]} : ~b;
      tx_en = rgmii ? en ^ er : ~en;
      tx_er = ~tx_er;
      gtx_clk = 1'b0;
      #100;
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the MAC-side port
`timescale 1ns/1ps
`default_nettype none
`include "phyp_map.vh"
module tb_top;
   logic       clk, rst, speed_1000, half_duplex, crs_on_tx_en, rx_active, tx_active, line_rx_valid, line_rx_err;
   logic       rgmii, got_en, got_err;
   logic [2:0] host_port_variant_select;
   logic [7:0] line_rx_data, got_data;
   wire logic  gtx_clk, tx_en, tx_er, line_rx_take, line_tx_valid, line_tx_en, line_tx_err, rx_clk, rx_dv, rx_er, crs, col;
   wire logic [7:0] txd, line_tx_data, rxd;
   wire logic [1:0] port_mode;
   integer     miscompares = 0, check_count = 0, n_got = 0;
   phyp_mac_port dut_u (.*);
   phyp_mac_model mac_u (.*);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Strobe lasts one cycle, so it is caught here rather than polled
   always @(negedge clk)
      if (line_tx_valid === 1'b1)
      begin
         {got_data, got_en, got_err} = {line_tx_data, line_tx_en, line_tx_err};
         n_got = n_got + 1;
      end
   task tick(input integer n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      check_count = check_count + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task wait_rx(input logic v);
      integer i;
      for (i = 0; i < 9 && rx_clk !== v; i = i + 1)
         tick(1);
      if (rx_clk !== v)
      begin
         miscompares = miscompares + 1;
         end_of_test;
      end
   endtask
   task rst_to(input logic [2:0] s);
      {rst, host_port_variant_select} = {1'b1, s};
      tick(8);
      rst = 1'b0;
      tick(3);
   endtask
   task tx(input logic [7:0] b, input logic en, input logic er, input logic n);
      integer n0;
      n0 = n_got;
      mac_u.send(b, en, er);
      tick(8);
      chk(8'(n_got - n0), {7'h0, n});
      if (n)
         chk({got_data ^ b, 4'h0, got_en, got_err}, {12'h000, en, er});
   endtask
   task rx(input logic [7:0] b, input logic v, input logic e);
      {line_rx_valid, line_rx_err, line_rx_data} = {v, e, b};
      wait_rx(1'b0);
      wait_rx(1'b1);
      if (rgmii)
         chk({rx_dv, rxd[6:0]}, {v, 3'h0, b[3:0]});
      wait_rx(1'b0);
      chk({rx_dv, rx_er, rxd}, rgmii ? {v ^ e, 5'h00, b[7:4]} : {v, v & e, b});
   endtask
   task t_strap;
      integer s;
      logic [1:0] m;
      for (s = 0; s < 8; s = s + 1)
      begin
         m = s == 0 ? `PHYP_MODE_GMII : (s == 4 || s == 6) ? `PHYP_MODE_RGMII : `PHYP_MODE_OFF;
         rst_to(s[2:0]);
         chk({6'h00, port_mode}, {6'h00, m});
         host_port_variant_select = ~host_port_variant_select;
         tick(4);
         chk({6'h00, port_mode}, {6'h00, m});
      end
      $display("strap test done");
   endtask
   task t_port(input logic [2:0] s);
      rst_to(s);
      rgmii = s != `PHYP_SEL_GMII;
      tx(8'hA5, 1'b1, 1'b0, 1'b1);
      tx(8'h3C, 1'b1, 1'b1, 1'b1);
      rx(8'h96, 1'b1, 1'b1);
      rx(8'h69, 1'b1, 1'b0);
      rx(8'h5A, 1'b0, 1'b0);
      $display("port test done");
   endtask
   task t_off;
      wait_rx(1'b0);
      speed_1000 = 1'b0;
      tick(2);
      tx(8'h11, 1'b1, 1'b0, 1'b0);
      chk({7'h00, rx_clk}, 8'h00);
      speed_1000 = 1'b1;
      rst_to(3'h1);
      tx(8'h22, 1'b1, 1'b0, 1'b0);
      chk({rx_clk, rxd[6:0]}, 8'h00);
      $display("off test done");
   endtask
   task t_crs;
      integer k;
      for (k = 0; k < 16; k = k + 1)
      begin
         {half_duplex, crs_on_tx_en, rx_active, tx_active} = k[3:0];
         tick(2);
         chk({crs, col}, {rx_active | (half_duplex & crs_on_tx_en & tx_active),
              half_duplex & rx_active & tx_active});
      end
      $display("carrier test done");
   endtask
   initial
   begin
      {rst, speed_1000, half_duplex, crs_on_tx_en, rx_active, tx_active, line_rx_valid, line_rx_err, rgmii} = 9'h180;
      host_port_variant_select = 3'h0;
      line_rx_data = 8'h00;
      t_strap;
      t_port(`PHYP_SEL_GMII);
      t_port(`PHYP_SEL_RGMII_A);
      t_port(`PHYP_SEL_RGMII_B);
      t_off;
      t_crs;
      end_of_test;
   end
endmodule
`default_nettype wire
